/* rth_defines.vh */
// timing counts and state codes for the reset/test input handler
`ifndef RTH_DEFINES_VH
`define RTH_DEFINES_VH
// clock period in ns (125 MHz)
`define RTH_CLK_NS         8
// qualifying open time of the shared input, in ms
`define RTH_QUAL_MS        250
// monitoring open time after an output switch, in ms
`define RTH_MON_MS         200
// cycle counts of those times at the clock period, sized to the 25-bit open counter
`define RTH_QUAL_CYC       25'h1DCD650
`define RTH_MON_CYC        25'h17D7840
// self-test length in cycles, sized to its 5-bit counter
`define RTH_TEST_CYC       5'h10
// counter width
`define RTH_CNT_W          25
// one-hot state codes
`define RTH_ST_LOCK        5'h01
`define RTH_ST_LATCH       5'h02
`define RTH_ST_BLOCK       5'h04
`define RTH_ST_RUN         5'h08
`define RTH_ST_TEST        5'h10
`endif

/* rth_open_timer.v */
// open-interval timer for the shared reset/test input
`timescale 1ns/1ns
module rth_open_timer
(
    // clock and reset
    input  wire        ref_clk,
    input  wire        nrst,
    // sampled input, high while the switch is closed
    input  wire        closed,
    // thresholds in cycles
    input  wire [24:0] qual_lim,
    input  wire [24:0] mon_lim,
    // events
    output reg         qual_release,
    output reg         qual_reached,
    output reg         mon_reached
);
    reg [24:0] open_cnt;   // cycles the input has been open
    reg        qual_seen;  // current opening already qualified

    // count while open; report release after a qualifying opening
    always @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            open_cnt     <= 25'h0000000;
            qual_seen    <= 1'b0;
            qual_release <= 1'b0;
            qual_reached <= 1'b0;
            mon_reached  <= 1'b0;
        end
        else if (closed)
        begin
            // short openings drop out here unreported
            qual_release <= qual_seen;
            qual_seen    <= 1'b0;
            open_cnt     <= 25'h0000000;
            qual_reached <= 1'b0;
            mon_reached  <= 1'b0;
        end
        else
        begin
            qual_release <= 1'b0;
            if (open_cnt != 25'h1FFFFFF)
                open_cnt <= open_cnt + 25'h0000001;
            qual_reached <= (open_cnt + 25'h0000001 == qual_lim);
            mon_reached  <= (open_cnt + 25'h0000001 == mon_lim);
            if (open_cnt + 25'h0000001 >= qual_lim)
                qual_seen <= 1'b1;
        end
    end
endmodule // rth_open_timer

/* rth_handler.v */
// system state control driven by the shared reset/test/monitor input
`timescale 1ns/1ns
`include "rth_defines.vh"
// Notes on behaviour
// - one input resets, tests and monitors
// - valid operation in run means test
// - valid operation in latch/lockout means reset
// - input low at power-up forces lockout
// - valid operation: open quarter second, close
// - open beyond quarter second in run: test
// - monitor open over 200 ms: test cycle
// - latch mode holds blocked until manual reset
module rth_handler
(
    // clock and reset
    input  wire       ref_clk,
    input  wire       nrst,
    // shared input, high when switch closed to supply
    input  wire       reset_test_in,
    // beam, mode, fault and self-test inputs
    input  wire       beams_clear,
    input  wire       latch_mode,
    input  wire       fault,
    input  wire       self_test_fail,
    // outputs
    output reg        safety_output_pair,
    output reg        self_test_run,
    output reg        lockout,
    output reg        latched,
    output reg        reset_event
);
    localparam [24:0] QUAL_LIM = `RTH_QUAL_CYC;  // quarter second
    localparam [24:0] MON_LIM  = `RTH_MON_CYC;   // monitor window
    localparam [4:0]  ST_LOCK  = `RTH_ST_LOCK;
    localparam [4:0]  ST_LATCH = `RTH_ST_LATCH;
    localparam [4:0]  ST_BLOCK = `RTH_ST_BLOCK;
    localparam [4:0]  ST_RUN   = `RTH_ST_RUN;
    localparam [4:0]  ST_TEST  = `RTH_ST_TEST;

    reg  [4:0] state;        // one-hot system state
    reg  [4:0] next_state;   // next state
    reg        pwr_up;       // first cycle after reset release
    reg  [4:0] test_cnt;     // self-test length count
    reg        mon_armed;    // outputs switched recently
    wire       qual_release; // valid operation completed
    wire       qual_reached; // open reached a quarter second
    wire       mon_reached;  // open reached monitor limit

    // true in the cycle that moves the machine into tgt from another state
    function entering;
        input [4:0] cur; // present state
        input [4:0] nxt; // decoded next state
        input [4:0] tgt; // state of interest
        begin
            entering = (cur != tgt) && (nxt == tgt);
        end
    endfunction

    // registered view of one state, kept low in the power-up cycle
    function shown;
        input       up;  // power-up cycle flag
        input [4:0] nxt; // decoded next state
        input [4:0] tgt; // state the output reports
        begin
            shown = !up && (nxt == tgt);
        end
    endfunction

    // open-time measurement on the shared input
    rth_open_timer u_timer
    (
        .ref_clk      (ref_clk),
        .nrst         (nrst),
        // one input serves reset, test and monitoring
        .closed       (reset_test_in),
        // thresholds are fixed cycle counts
        .qual_lim     (QUAL_LIM),
        .mon_lim      (MON_LIM),
        .qual_release (qual_release),
        .qual_reached (qual_reached),
        .mon_reached  (mon_reached)
    );

    // next state decode
    always @*
    begin
        next_state = state;
        case (state)
            ST_LOCK:
            begin
                // reset out of lockout only on a valid operation
                if (qual_release && !fault)
                    next_state = ST_BLOCK;
            end
            ST_LATCH:
            begin
                // a fault outranks the latch
                if (fault)
                    next_state = ST_LOCK;
                // manual reset needs the beams clear
                else if (qual_release && beams_clear)
                    next_state = ST_RUN;
            end
            ST_BLOCK:
            begin
                // outputs stay off while any beam is blocked
                if (fault)
                    next_state = ST_LOCK;
                // clear beams: run, or latch when latching
                else if (beams_clear)
                    next_state = latch_mode ? ST_LATCH : ST_RUN;
            end
            ST_RUN:
            begin
                // a fault or a blocked beam drops the outputs first
                if (fault)
                    next_state = ST_LOCK;
                else if (!beams_clear)
                    next_state = latch_mode ? ST_LATCH : ST_BLOCK;
                // an opening that reaches a quarter second is a test request
                else if (qual_reached)
                    next_state = ST_TEST;
                // monitoring contacts still open long after outputs went on
                else if (mon_reached && mon_armed)
                    next_state = ST_TEST;
            end
            ST_TEST:
            begin
                // a failed self-test or a fault locks out
                if (self_test_fail || fault)
                    next_state = ST_LOCK;
                // leave once the count ran out and the input closed
                else if (test_cnt == 5'h00 && reset_test_in)
                    next_state = ST_BLOCK;
            end
            default:
            begin
                // an illegal code falls back to the safe state
                next_state = ST_LOCK;
            end
        endcase
    end

    // state register and power-up check
    always @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            // reset holds lockout until the input is looked at
            state  <= ST_LOCK;
            pwr_up <= 1'b1;
        end
        else
        begin
            pwr_up <= 1'b0;
            if (pwr_up)
            begin
                // input low or floating at power-up stays in lockout
                state <= reset_test_in ? ST_BLOCK : ST_LOCK;
            end
            else
            begin
                // normal operation follows the decode
                state <= next_state;
            end
        end
    end

    // self-test length and monitor window arming
    always @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            // counters idle after reset
            test_cnt  <= 5'h00;
            mon_armed <= 1'b0;
        end
        else
        begin
            // load the self-test length on entry to the test cycle
            if (entering(state, next_state, ST_TEST))
                test_cnt <= `RTH_TEST_CYC;
            else if (test_cnt != 5'h00)
                test_cnt <= test_cnt - 5'h01;
            // arm on entry to run, where outputs switch on
            if (entering(state, next_state, ST_RUN))
                mon_armed <= 1'b1;
            // the first closed sample or leaving run ends the window
            else if (reset_test_in || state != ST_RUN)
                mon_armed <= 1'b0;
        end
    end

    // registered outputs
    always @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            // reset shows lockout with both outputs off
            safety_output_pair <= 1'b0;
            self_test_run      <= 1'b0;
            lockout            <= 1'b1;
            latched            <= 1'b0;
            reset_event        <= 1'b0;
        end
        else
        begin
            // outputs on only in run; test drops them
            safety_output_pair <= shown(pwr_up, next_state, ST_RUN);
            // test cycle flag mirrors the state
            self_test_run      <= shown(pwr_up, next_state, ST_TEST);
            // power-up cycle reports the input level directly
            lockout            <= pwr_up ? !reset_test_in : (next_state == ST_LOCK);
            // latch indicator
            latched            <= shown(pwr_up, next_state, ST_LATCH);
            // one pulse when a valid operation actually leaves lock or latch
            reset_event        <= !pwr_up && qual_release &&
                                  ((state == ST_LOCK && next_state == ST_BLOCK) ||
                                   (state == ST_LATCH && next_state == ST_RUN));
        end
    end
endmodule // rth_handler

/* rth_props.sv */
// checker for the reset/test input handler
`timescale 1ns/1ns
module rth_props
(
    // clock and reset
    input wire ref_clk, nrst,
    // inputs
    input wire reset_test_in, beams_clear, latch_mode, fault, self_test_fail,
    // outputs
    input wire safety_output_pair, self_test_run, lockout, latched, reset_event
);
    localparam int MON = 25000000; // shortest opening that may start a test
    localparam int QUAL = 31250000; // shortest opening that counts as a reset
    int open_cnt;                  // length of the current opening
    int peak;                      // longest opening since reset
    // measure openings of the shared input
    always @(posedge ref_clk)
    begin
        open_cnt <= (!nrst || reset_test_in) ? 0 : open_cnt + 1;
        peak     <= !nrst ? 0 : (open_cnt > peak ? open_cnt : peak);
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    a_pwr_low_lock: assert property ($rose(nrst) && !reset_test_in |=> lockout)
        else $error("no lockout after power-up with input open");
    a_pwr_high_free: assert property ($rose(nrst) && reset_test_in && !fault |-> ##[1:3] !lockout)
        else $error("lockout after power-up with input closed");
    a_held_outputs_off: assert property (lockout || latched |-> !safety_output_pair)
        else $error("outputs on while locked or latched");
    a_test_outputs_off: assert property (self_test_run |-> !safety_output_pair)
        else $error("outputs on during test cycle");
    a_short_no_test: assert property ($rose(self_test_run) |-> peak >= MON - 4 || open_cnt >= MON - 4)
        else $error("test started after short opening");
    a_short_no_reset: assert property (reset_event |-> peak >= QUAL)
        else $error("reset after short opening");
    a_event_one_cycle: assert property (reset_event |=> !reset_event)
        else $error("reset event longer than one cycle");
    a_fault_locks: assert property (fault |-> ##[1:3] lockout)
        else $error("fault did not lock out");
    a_run_needs_clear: assert property ($rose(safety_output_pair) |-> $past(beams_clear) || $past(beams_clear, 2))
        else $error("outputs on with beams blocked");
endmodule // rth_props
bind rth_handler rth_props u_rth_props (.ref_clk(ref_clk), .nrst(nrst), .reset_test_in(reset_test_in),
    .beams_clear(beams_clear), .latch_mode(latch_mode), .fault(fault), .self_test_fail(self_test_fail),
    .safety_output_pair(safety_output_pair), .self_test_run(self_test_run), .lockout(lockout),
    .latched(latched), .reset_event(reset_event));

/* rth_switch_model.sv */
// normally closed reset switch driving the shared input
`timescale 1ns/1ns
module rth_switch_model
(
    // clock
    input  wire        ref_clk,
    // bench control
    input  wire        wired,    // switch connected; unconnected reads low
    input  wire [15:0] open_len, // cycles to hold the switch open
    input  wire        go,       // start one opening
    // shared input line
    // the only line to the receiver; restarting motion is left to the machine
    output wire        contact
);
    reg [15:0] left = 16'h0000; // open cycles still to run
    // closed unless counting an opening
    assign contact = wired && left == 16'h0000;
    // opening countdown, changes just after the edge
    always @(posedge ref_clk)
        left <= go ? open_len : (left != 16'h0000 ? left - 16'h0001 : left);
endmodule // rth_switch_model

/* reset_test_input_handler_test.sv */
// self-checking bench for the reset/test input handler
`timescale 1ns/1ns
`define RTH_CMP(nm, e, s) begin total_checks++; if ((s) !== (e)) begin err_count++; \
    $display("unexpected %s expected %b seen %b", nm, e, s); end end
module reset_test_input_handler_test;
    reg        ref_clk = 1'b0, nrst = 1'b0, beams_clear = 1'b1, latch_mode = 1'b0, fault = 1'b0;
    reg        wired = 1'b1, go = 1'b0, chk = 1'b0;
    reg [15:0] open_len = 16'h0001;
    reg [4:0]  expq [$]; // expected {lockout, outputs, test, latched, reset event}
    reg [4:0]  exp_v;
    wire       reset_test_in, safety_output_pair, self_test_run, lockout, latched, reset_event;
    wire [4:0] seen = {lockout, safety_output_pair, self_test_run, latched, reset_event}; // observed outputs
    int        err_count = 0, total_checks = 0, cyc = 0, i;
    always #4 ref_clk = ~ref_clk;
    rth_switch_model u_rth_switch_model (.ref_clk(ref_clk), .wired(wired), .open_len(open_len), .go(go),
        .contact(reset_test_in));
    rth_handler u_rth_handler (.ref_clk(ref_clk), .nrst(nrst), .reset_test_in(reset_test_in),
        .beams_clear(beams_clear), .latch_mode(latch_mode), .fault(fault), .self_test_fail(1'b0),
        .safety_output_pair(safety_output_pair), .self_test_run(self_test_run), .lockout(lockout),
        .latched(latched), .reset_event(reset_event));
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // note an expected state for the watcher
    task automatic note(input [4:0] e);
    begin
        expq.push_back(e);
        chk = 1'b1;
        tick(1);
        chk = 1'b0;
    end
    endtask
    task automatic do_reset(input w);
    begin
        nrst = 1'b0;
        wired = w;
        tick(20);
        nrst = 1'b1;
        tick(8);
    end
    endtask
    task automatic pulse_open(input [15:0] n);
    begin
        open_len = n;
        go = 1'b1;
        tick(1);
        go = 1'b0;
        tick(n + 8);
    end
    endtask
    task automatic summarize;
    begin
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask
    // watcher: compare oldest note with the outputs
    always @(posedge ref_clk)
        if (chk)
        begin
            exp_v = expq.pop_front();
            `RTH_CMP("state", exp_v, seen)
        end
    // hang guard; the longest run needs about 19,000 cycles
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            err_count++;
            summarize();
        end
    end
    initial
    begin
        void'($urandom(71791));
        // power-up with the switch closed: blocked, then run
        do_reset(1'b1);
        note(5'h08);
        // short random openings in run are ignored
        for (i = 0; i < 8; i++)
        begin
            pulse_open(16'($urandom % 2000 + 1));
            note(5'h08);
        end
        // trip operation: blocked beams drop the outputs, clear beams restore them
        beams_clear = 1'b0;
        tick(4);
        note(5'h00);
        beams_clear = 1'b1;
        tick(4);
        note(5'h08);
        // latch operation holds after the beams clear
        latch_mode = 1'b1;
        beams_clear = 1'b0;
        tick(6);
        note(5'h02);
        beams_clear = 1'b1;
        tick(6);
        pulse_open(16'h0384);
        note(5'h02);
        // a fault in latch locks out; a short opening does not reset it
        fault = 1'b1;
        tick(4);
        note(5'h10);
        fault = 1'b0;
        pulse_open(16'h05DC);
        note(5'h10);
        // input floating at power-up locks out and stays so once it closes
        do_reset(1'b0);
        note(5'h10);
        wired = 1'b1;
        tick(4);
        note(5'h10);
        // power-up in latch operation waits for a manual reset
        do_reset(1'b1);
        note(5'h02);
        summarize();
    end
endmodule // reset_test_input_handler_test
